// *** core/adc_output_and_calibration.sv ***
// digital side of the pipelined converter: sequencing, calibration, output latch
`timescale 1ns/1ps
`default_nettype none
module adc_output_and_calibration
  import adc_out_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_MIN_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // raw comparator result: 9-bit level, bit 8 set above full scale
  input wire logic [RAW_W-1:0] raw_level,
  // calibration comparator feedback, 1 = measured high
  input wire logic zero_cmp_high,
  input wire logic gain_cmp_high,
  // output float control, from a pin
  input wire logic output_float_ctl_n,
  // data pins as output plus enable
  output logic [CODE_W-1:0] sample_code,
  output logic [CODE_W-1:0] sample_code_oe,
  output logic over_range_flag,
  output logic over_range_flag_oe,
  output logic word_valid_strobe,
  // sequencing and calibration status
  output logic [3:0] sample_section,
  output logic cal_settled,
  output logic [TRIM_W-1:0] offset_trim,
  output logic [TRIM_W-1:0] gain_trim
);
  typedef enum logic [1:0] {
    CAL_START = 2'b00,
    CAL_INITIAL = 2'b01,
    CAL_TRACK = 2'b10
  } cal_state_e;

  cal_state_e cal_state_reg;
  logic [CAL_W-1:0] cal_count_reg;
  logic [3:0] section_reg;
  logic [3:0] section_phase;
  logic [TRIM_W-1:0] offset_reg;
  logic [TRIM_W-1:0] gain_reg;
  logic [RAW_W-1:0] delayed_level;
  logic [2:0] float_sync_reg;
  logic float_state_reg;
  logic valid_reg;
  logic [CODE_W-1:0] code_reg;
  logic over_reg;

  // rotate sampling over the sections, one per clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      section_reg <= '0;
    end else begin
      section_reg <= section_reg + 4'h1;
    end
  end

  // section 0 is at sample phase when section_reg lands on it; others trail by index
  assign section_phase = section_reg + PH_SAMPLE;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sample_section <= '0;
    end else begin
      sample_section <= section_reg;
    end
  end

  // power-up calibration sequencer; clock stopping simply freezes it, which is why
  // the far end must keep the clock running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cal_state_reg <= CAL_START;
      cal_count_reg <= '0;
    end else begin
      case (cal_state_reg)
        CAL_START: begin
          cal_count_reg <= '0;
          cal_state_reg <= CAL_INITIAL;
        end
        CAL_INITIAL: begin
          if (cal_count_reg >= CAL_W'(CAL_CYCLES - 2)) begin
            cal_state_reg <= CAL_TRACK;
          end
          cal_count_reg <= cal_count_reg + 1'b1;
        end
        CAL_TRACK: begin
          cal_count_reg <= cal_count_reg;
        end
        default: begin
          cal_state_reg <= CAL_START;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cal_settled <= 1'b0;
    end else begin
      cal_settled <= (cal_state_reg == CAL_TRACK);
    end
  end

  // closed-loop trims: one fractional step per comparison phase, never stopping,
  // so tracking continues in the background while samples keep flowing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      offset_reg <= TRIM_MID;
    end else if (cal_state_reg != CAL_START && section_phase == PH_ZERO_CMP) begin
      if (zero_cmp_high && offset_reg != '0) begin
        offset_reg <= offset_reg - 1'b1;
      end else if (!zero_cmp_high && offset_reg != '1) begin
        offset_reg <= offset_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gain_reg <= TRIM_MID;
    end else if (cal_state_reg != CAL_START && section_phase == PH_GAIN_CMP) begin
      if (gain_cmp_high && gain_reg != '0) begin
        gain_reg <= gain_reg - 1'b1;
      end else if (!gain_cmp_high && gain_reg != '1) begin
        gain_reg <= gain_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      offset_trim <= TRIM_MID;
      gain_trim <= TRIM_MID;
    end else begin
      offset_trim <= offset_reg;
      gain_trim <= gain_reg;
    end
  end

  // pipeline: 11 stages here plus the output register give 12 clocks
  adc_delay_line #(
    .WIDTH(RAW_W),
    .DEPTH(LATENCY - 1)
  ) u_delay (
    .mclk(mclk),
    .reset_n(reset_n),
    .din(raw_level),
    .dout(delayed_level)
  );

  // output latch on every rising edge, overrange saturates the code
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      code_reg <= '0;
      over_reg <= 1'b0;
    end else if (delayed_level > FULL_SCALE) begin
      over_reg <= 1'b1;
      code_reg <= CODE_MAX;
    end else begin
      over_reg <= 1'b0;
      code_reg <= delayed_level[CODE_W-1:0];
    end
  end

  assign sample_code = code_reg;
  assign over_range_flag = over_reg;

  // float control comes from a pin: three flops, act when last two agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      float_sync_reg <= 3'b111;
    end else begin
      float_sync_reg <= {float_sync_reg[1:0], output_float_ctl_n};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      float_state_reg <= 1'b1;
    end else if (float_sync_reg[2] == float_sync_reg[1]) begin
      float_state_reg <= float_sync_reg[1];
    end
  end

  // enables held low (floating) while the control is high
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sample_code_oe <= '0;
      over_range_flag_oe <= 1'b0;
    end else begin
      sample_code_oe <= {CODE_W{~float_state_reg}};
      over_range_flag_oe <= ~float_state_reg;
    end
  end

  // valid strobe flips each clock, edge marks a fresh word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= ~valid_reg;
    end
  end

  assign word_valid_strobe = valid_reg;
endmodule
`default_nettype wire

// *** shared/adc_out_pkg.sv ***
// constants for the converter output and calibration block
// Notes on behaviour
// - after power-up calibration runs at least 10,000 clocks before settled.
// - gain and offset keep adjusting in background without interrupting output.
// - all pipelined activity advances only on rising clock edges.
// - sample code and overrange flag are registered on each rising edge.
// - output control high floats all nine data outputs, overrange included.
// - result is 8-bit straight binary, lsb on lowest output bit.
// - overrange flag is one when input exceeds full scale by one lsb.
// - while overrange flag is one all eight code bits read ones.
// - output code appears twelve clocks after its sample is taken.
// - input sampled every clock, rotating over sixteen sections of 16-cycle sequence.
package adc_out_pkg;
  localparam int CODE_W = 8;
  localparam int RAW_W = 9;
  localparam int SECTIONS = 16;
  localparam int SEQ_LEN = 16;
  localparam int LATENCY = 12;
  localparam int CAL_MIN_CYCLES = 10000;
  localparam int CAL_W = 14;
  localparam int TRIM_W = 6;
  localparam logic [RAW_W-1:0] FULL_SCALE = 9'h0ff;
  localparam logic [CODE_W-1:0] CODE_MAX = 8'hff;
  localparam logic [TRIM_W-1:0] TRIM_MID = 6'h20;
  // position in each section's 16-cycle sequence
  localparam logic [3:0] PH_REF_ZERO = 4'h0;
  localparam logic [3:0] PH_ZERO_CMP = 4'h1;
  localparam logic [3:0] PH_GAIN_CMP = 4'h2;
  localparam logic [3:0] PH_SAMPLE = 4'h3;
  localparam logic [3:0] PH_XFER = 4'hf;
endpackage

// *** core/adc_delay_line.sv ***
// fixed-length register pipeline carrying a word a set number of clocks
`timescale 1ns/1ps
`default_nettype none
module adc_delay_line #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_reg [DEPTH];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign dout = stage_reg[DEPTH-1];
endmodule
`default_nettype wire

// *** dv/adc_output_and_calibration_asserts.sv ***
// port assertions for the converter output block
`timescale 1ns/1ps
`default_nettype none
module adc_out_checker
  import adc_out_pkg::*;
#(parameter int CAL_CYCLES = CAL_MIN_CYCLES) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // watched ports
  input wire logic [RAW_W-1:0] raw_level,
  input wire logic output_float_ctl_n,
  input wire logic [CODE_W-1:0] sample_code,
  input wire logic [CODE_W-1:0] sample_code_oe,
  input wire logic over_range_flag,
  input wire logic over_range_flag_oe,
  input wire logic word_valid_strobe,
  input wire logic [3:0] sample_section,
  input wire logic cal_settled,
  input wire logic [TRIM_W-1:0] gain_trim
);
  logic [15:0] cyc_reg;
  // edges since release; the latency checks wait until the pipe holds only fresh samples
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cyc_reg <= 16'h0000;
    else if (cyc_reg != 16'hffff) cyc_reg <= cyc_reg + 16'h0001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_code_latency: assert property (cyc_reg > 16'h000d
    && $past(raw_level, 12) <= FULL_SCALE
    |-> sample_code == CODE_W'($past(raw_level, 12))) else $error("code latency wrong");
  a_flag_latency: assert property (cyc_reg > 16'h000d
    |-> over_range_flag == ($past(raw_level, 12) > FULL_SCALE)) else $error("flag wrong");
  a_over_forces: assert property (over_range_flag |-> sample_code == CODE_MAX)
    else $error("code not all ones");
  // sync, settle and enable flops put five edges between the pin and the enables
  a_float_off: assert property ((output_float_ctl_n) [*6]
    |-> sample_code_oe == 8'h00 && !over_range_flag_oe) else $error("outputs not floated");
  a_drive_on: assert property ((!output_float_ctl_n) [*6]
    |-> sample_code_oe == 8'hff && over_range_flag_oe) else $error("outputs not driven");
  a_strobe_toggle: assert property (cyc_reg > 16'h0001
    |-> word_valid_strobe != $past(word_valid_strobe)) else $error("strobe did not toggle");
  a_section_step: assert property (cyc_reg > 16'h0001
    |-> sample_section == 4'($past(sample_section) + 4'h1)) else $error("section skipped");
  a_settle_time: assert property (cal_settled |-> cyc_reg >= CAL_CYCLES)
    else $error("settled too early");
  a_trim_step: assert property (cyc_reg > 16'h0001
    |-> TRIM_W'(gain_trim - $past(gain_trim)) inside {6'h00, 6'h01, 6'h3f})
    else $error("trim jumped");
  c_over: cover property (over_range_flag);
  c_settle: cover property ($rose(cal_settled));
  c_float: cover property (!over_range_flag_oe);
endmodule
bind adc_output_and_calibration adc_out_checker #(.CAL_CYCLES(CAL_CYCLES)) i_chk (
  .mclk(mclk),
  .reset_n(reset_n),
  .raw_level(raw_level),
  .output_float_ctl_n(output_float_ctl_n),
  .sample_code(sample_code),
  .sample_code_oe(sample_code_oe),
  .over_range_flag(over_range_flag),
  .over_range_flag_oe(over_range_flag_oe),
  .word_valid_strobe(word_valid_strobe),
  .sample_section(sample_section),
  .cal_settled(cal_settled),
  .gain_trim(gain_trim)
);
`default_nettype wire

// *** dv/adc_sample_capture.sv ***
// downstream capture logic model: resolves the tri-state pins and counts words
`timescale 1ns/1ps
`default_nettype none
module adc_sample_capture
  import adc_out_pkg::*;
(
  // clock
  input wire logic mclk,
  // pins from the converter
  input wire logic [CODE_W-1:0] sample_code,
  input wire logic [CODE_W-1:0] sample_code_oe,
  input wire logic over_range_flag,
  input wire logic over_range_flag_oe,
  input wire logic word_valid_strobe,
  // resolved wire and capture count
  output logic [RAW_W-1:0] pin_level,
  output logic [15:0] word_count
);
  logic [RAW_W-1:0] en;
  logic [RAW_W-1:0] last_reg = 9'h000;
  logic strobe_reg = 1'b0;
  assign en = {over_range_flag_oe, sample_code_oe};
  // a floated pin shows the inverse of its last level so a stale value never passes
  assign pin_level = (en & {over_range_flag, sample_code}) | (~en & ~last_reg);
  initial word_count = 16'h0000;
  always @(posedge mclk) begin
    last_reg <= pin_level;
    if (word_valid_strobe != strobe_reg) word_count <= word_count + 16'h0001;
    strobe_reg <= word_valid_strobe;
  end
endmodule
`default_nettype wire

// *** dv/adc_output_and_calibration_test.sv ***
// self-checking bench for the converter output and calibration block
`timescale 1ns/1ps
`default_nettype none
module adc_output_and_calibration_test;
  import adc_out_pkg::*;
  localparam int CAL = 20;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [RAW_W-1:0] raw_level = 9'h000;
  logic zero_cmp_high = 1'b1;
  logic gain_cmp_high = 1'b0;
  logic output_float_ctl_n = 1'b0;
  logic [CODE_W-1:0] sample_code, sample_code_oe;
  logic over_range_flag, over_range_flag_oe, word_valid_strobe, cal_settled;
  logic [3:0] sample_section;
  logic [TRIM_W-1:0] offset_trim, gain_trim;
  logic [RAW_W-1:0] pin_level;
  logic [15:0] word_count;
  int err_total = 0;
  int check_count = 0;
  // the clock never stops, calibration depends on it
  always #5 mclk = ~mclk;
  adc_output_and_calibration #(.CAL_CYCLES(CAL)) i_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw_level(raw_level),
    .zero_cmp_high(zero_cmp_high),
    .gain_cmp_high(gain_cmp_high),
    .output_float_ctl_n(output_float_ctl_n),
    .sample_code(sample_code),
    .sample_code_oe(sample_code_oe),
    .over_range_flag(over_range_flag),
    .over_range_flag_oe(over_range_flag_oe),
    .word_valid_strobe(word_valid_strobe),
    .sample_section(sample_section),
    .cal_settled(cal_settled),
    .offset_trim(offset_trim),
    .gain_trim(gain_trim)
  );
  adc_sample_capture i_cap (
    .mclk(mclk),
    .sample_code(sample_code),
    .sample_code_oe(sample_code_oe),
    .over_range_flag(over_range_flag),
    .over_range_flag_oe(over_range_flag_oe),
    .word_valid_strobe(word_valid_strobe),
    .pin_level(pin_level),
    .word_count(word_count)
  );
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_cal();
    int n;
    n = 0;
    while (!cal_settled && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n == 200) begin
      err_total++;
      report_and_stop();
    end
    check("settle", 16'(n >= CAL), 16'h0001);
    check("offset", 16'(offset_trim < TRIM_MID), 16'h0001);
    check("gain", 16'(gain_trim > TRIM_MID), 16'h0001);
  endtask
  task automatic t_data();
    logic [RAW_W-1:0] v [0:5];
    v = '{9'h000, 9'h0ff, 9'h100, 9'h1ff, 9'h001, 9'h0a5};
    for (int i = 0; i < 18; i++) begin
      @(negedge mclk);
      if (i >= 12) check("pins", 16'(pin_level), v[i-12][8] ? 16'h01ff : 16'(v[i-12]));
      raw_level = (i < 6) ? v[i] : 9'h000;
    end
  endtask
  task automatic t_seq();
    logic [15:0] c;
    logic [3:0] s;
    c = word_count;
    s = sample_section;
    repeat (5) @(negedge mclk);
    check("section", 16'(sample_section), 16'(4'(s + 4'h5)));
    repeat (11) @(negedge mclk);
    check("section_wrap", 16'(sample_section), 16'(s));
    check("words", word_count, c + 16'h0010);
  endtask
  task automatic t_track();
    logic [TRIM_W-1:0] o;
    logic [TRIM_W-1:0] g;
    zero_cmp_high = 1'b0;
    gain_cmp_high = 1'b1;
    // let a step taken in the old direction reach the trim outputs first
    repeat (17) @(negedge mclk);
    o = offset_trim;
    g = gain_trim;
    repeat (32) @(negedge mclk);
    check("offset_up", 16'(offset_trim), 16'(6'(o + 6'h02)));
    check("gain_down", 16'(gain_trim), 16'(6'(g - 6'h02)));
  endtask
  task automatic t_float();
    output_float_ctl_n = 1'b1;
    repeat (5) @(negedge mclk);
    check("oe_off", {7'h00, over_range_flag_oe, sample_code_oe}, 16'h0000);
    output_float_ctl_n = 1'b0;
    repeat (5) @(negedge mclk);
    check("oe_on", {7'h00, over_range_flag_oe, sample_code_oe}, 16'h01ff);
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    t_cal();
    t_data();
    t_seq();
    t_track();
    t_float();
    t_data();
    report_and_stop();
  end
endmodule
`default_nettype wire
